// [common/pda_pkg.sv]
/*
  Package for the loop deviation and fault alarm output block: function codes,
  widths, reset routing and the packed carriers used at the block's ports.
  Assumes a single 40 MHz control clock and synchronous, active-low reset.
*/
// What this block does
// - The loop error is the absolute difference between target and measured value, never negative.
// - An output assigned function code 04 shows the deviation flag, active when the error exceeds the threshold.
// - The deviation flag is inactive whenever the error is below the threshold.
// - The alarm flag is asserted while the drive is tripped after a fault.
// - The alarm flag drops once the fault is cleared and the drive leaves the trip state.
// - The alarm flag may be routed to any of open-collector outputs 11 to 15 or to the relay.
// - After reset the relay carries the alarm flag.
// - Function code 05 selects the alarm flag, which follows the trip state one cycle later and is not latched.
// - Open-collector outputs are active low: the transistor conducts while the assigned flag is set.
package pda_pkg;
  localparam int PDA_VAL_W = 16;
  localparam int PDA_FUNC_W = 6;
  localparam int PDA_NUM_OC = 5;
  localparam logic [PDA_FUNC_W-1:0] PDA_FN_DEVIATION = 6'h04;
  localparam logic [PDA_FUNC_W-1:0] PDA_FN_ALARM = 6'h05;
  localparam logic [PDA_FUNC_W-1:0] PDA_FN_NONE = 6'h3F;
  localparam logic [PDA_FUNC_W-1:0] PDA_RST_RELAY_FN = PDA_FN_ALARM;
  localparam logic [PDA_FUNC_W-1:0] PDA_RST_OC_FN = PDA_FN_NONE;

  typedef struct packed {
    logic [PDA_VAL_W-1:0] target;
    logic [PDA_VAL_W-1:0] measured;
  } pda_loop_t;

  typedef struct packed {
    logic [PDA_NUM_OC-1:0][PDA_FUNC_W-1:0] oc_func;
    logic [PDA_FUNC_W-1:0] relay_func;
  } pda_route_t;
endpackage

// [design/pda_outputs.sv]
/*
  Loop deviation and fault alarm flags, routed to five open-collector outputs
  and the relay. Assumes inputs synchronous to clock; the routing codes are
  captured on a load strobe and fall back to defaults under reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pda_outputs (
  input wire logic clock,
  input wire logic rst_n,
  input wire pda_pkg::pda_loop_t loop_in,
  input wire logic [pda_pkg::PDA_VAL_W-1:0] deviation_threshold_setting,
  input wire logic tripped,
  input wire logic route_load,
  input wire pda_pkg::pda_route_t route_in,
  output logic loop_deviation_flag,
  output logic fault_alarm_flag,
  output logic [pda_pkg::PDA_NUM_OC-1:0] oc_out_n,
  output logic relay_energise
);
  import pda_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [PDA_VAL_W-1:0] abs_diff(input logic [PDA_VAL_W-1:0] a,
                                                   input logic [PDA_VAL_W-1:0] b);
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction

  function automatic logic pick(input logic [PDA_FUNC_W-1:0] fn, input logic dev, input logic alm);
    pick = (fn == PDA_FN_DEVIATION) ? dev :
           (fn == PDA_FN_ALARM) ? alm : 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [PDA_VAL_W-1:0] err;
  logic dev_d;
  pda_route_t route_q;

  assign err = abs_diff(loop_in.target, loop_in.measured);
  // Strict compare keeps equality inactive, evaluated every cycle.
  assign dev_d = err > deviation_threshold_setting;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      loop_deviation_flag <= 1'b0;
    end else begin
      loop_deviation_flag <= dev_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fault_alarm_flag <= 1'b0;
    end else begin
      fault_alarm_flag <= tripped;
    end
  end

  // Reset wins over a load strobe in the same cycle, so defaults are always restored.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      route_q.relay_func <= PDA_RST_RELAY_FN;
      for (int i = 0; i < PDA_NUM_OC; i++) begin
        route_q.oc_func[i] <= PDA_RST_OC_FN;
      end
    end else if (route_load) begin
      route_q <= route_in;
    end
  end

  // Outputs follow the registered flags, so they lag the flags by one cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oc_out_n <= '1;
      relay_energise <= 1'b0;
    end else begin
      for (int i = 0; i < PDA_NUM_OC; i++) begin
        oc_out_n[i] <= ~pick(route_q.oc_func[i], loop_deviation_flag, fault_alarm_flag);
      end
      relay_energise <= pick(route_q.relay_func, loop_deviation_flag, fault_alarm_flag);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The 17-bit sums rebuild the larger input from the error and the smaller one,
  // so a wrapped or signed difference cannot slip through.
  chk_err_magnitude: assert property (@(posedge clock) disable iff (!rst_n)
    ((({1'b0, err} + {1'b0, loop_in.measured}) == {1'b0, loop_in.target}) ||
     (({1'b0, err} + {1'b0, loop_in.target}) == {1'b0, loop_in.measured})))
    else $error("loop error not absolute");
  chk_dev_above: assert property (@(posedge clock) disable iff (!rst_n)
    (err > deviation_threshold_setting)
    |=> loop_deviation_flag)
    else $error("deviation flag missed");
  chk_dev_below: assert property (@(posedge clock) disable iff (!rst_n)
    (err < deviation_threshold_setting)
    |=> !loop_deviation_flag)
    else $error("deviation flag false");
  chk_dev_equal: assert property (@(posedge clock) disable iff (!rst_n)
    (err == deviation_threshold_setting)
    |=> !loop_deviation_flag)
    else $error("equal error flagged");

  ////////////////////////////////////////////////////////////////////////////
  // Alarm flag. A trip of a single cycle shows for a single cycle; nothing stretches it.
  chk_alarm_set: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(tripped)
    |=> fault_alarm_flag)
    else $error("alarm not raised");
  chk_alarm_clear: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(tripped)
    |=> !fault_alarm_flag)
    else $error("alarm not cleared");
  chk_alarm_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (tripped [*2])
    |-> fault_alarm_flag)
    else $error("alarm dropped while tripped");
  chk_alarm_follow: assert property (@(posedge clock) disable iff (!rst_n)
    tripped
    |=> fault_alarm_flag)
    else $error("alarm missing while tripped");
  chk_alarm_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !tripped
    |=> !fault_alarm_flag)
    else $error("alarm present while not tripped");

  ////////////////////////////////////////////////////////////////////////////
  // Routing codes and the values that reset restores.
  chk_route_load: assert property (@(posedge clock) disable iff (!rst_n)
    route_load
    |=> (route_q == $past(route_in)))
    else $error("routing codes not loaded");
  chk_route_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !route_load
    |=> (route_q == $past(route_q)))
    else $error("routing codes changed without load");
  chk_reset_route: assert property (@(posedge clock)
    !rst_n
    |=> (route_q.relay_func == PDA_FN_ALARM))
    else $error("relay default lost");
  chk_reset_oc_route: assert property (@(posedge clock)
    !rst_n
    |=> (route_q.oc_func == {PDA_NUM_OC{PDA_RST_OC_FN}}))
    else $error("open collector default lost");
  chk_reset_outputs: assert property (@(posedge clock)
    !rst_n
    |=> ((oc_out_n == '1) && !relay_energise && !loop_deviation_flag && !fault_alarm_flag))
    else $error("outputs not idle after reset");

  ////////////////////////////////////////////////////////////////////////////
  // Relay, active high.
  chk_relay_alarm: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.relay_func == PDA_FN_ALARM)
    |=> (relay_energise == $past(fault_alarm_flag)))
    else $error("relay not following alarm");
  chk_relay_dev: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.relay_func == PDA_FN_DEVIATION)
    |=> (relay_energise == $past(loop_deviation_flag)))
    else $error("relay not following deviation");
  chk_relay_none: assert property (@(posedge clock) disable iff (!rst_n)
    ((route_q.relay_func != PDA_FN_DEVIATION) && (route_q.relay_func != PDA_FN_ALARM))
    |=> !relay_energise)
    else $error("unrouted relay energised");

  ////////////////////////////////////////////////////////////////////////////
  // Open collectors, three checks per terminal; a low pin means the transistor conducts.
  chk_oc_low: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.oc_func[0] == PDA_FN_DEVIATION)
    |=> (oc_out_n[0] == !$past(loop_deviation_flag)))
    else $error("open collector polarity wrong");
  chk_oc0_alarm: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.oc_func[0] == PDA_FN_ALARM)
    |=> (oc_out_n[0] == !$past(fault_alarm_flag)))
    else $error("open collector 0 not following alarm");
  chk_oc0_none: assert property (@(posedge clock) disable iff (!rst_n)
    ((route_q.oc_func[0] != PDA_FN_DEVIATION) && (route_q.oc_func[0] != PDA_FN_ALARM))
    |=> oc_out_n[0])
    else $error("unrouted open collector 0 conducting");
  chk_oc1_dev: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.oc_func[1] == PDA_FN_DEVIATION)
    |=> (oc_out_n[1] == !$past(loop_deviation_flag)))
    else $error("open collector 1 not following deviation");
  chk_oc1_alarm: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.oc_func[1] == PDA_FN_ALARM)
    |=> (oc_out_n[1] == !$past(fault_alarm_flag)))
    else $error("open collector 1 not following alarm");
  chk_oc1_none: assert property (@(posedge clock) disable iff (!rst_n)
    ((route_q.oc_func[1] != PDA_FN_DEVIATION) && (route_q.oc_func[1] != PDA_FN_ALARM))
    |=> oc_out_n[1])
    else $error("unrouted open collector 1 conducting");
  chk_oc2_dev: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.oc_func[2] == PDA_FN_DEVIATION)
    |=> (oc_out_n[2] == !$past(loop_deviation_flag)))
    else $error("open collector 2 not following deviation");
  chk_oc2_alarm: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.oc_func[2] == PDA_FN_ALARM)
    |=> (oc_out_n[2] == !$past(fault_alarm_flag)))
    else $error("open collector 2 not following alarm");
  chk_oc2_none: assert property (@(posedge clock) disable iff (!rst_n)
    ((route_q.oc_func[2] != PDA_FN_DEVIATION) && (route_q.oc_func[2] != PDA_FN_ALARM))
    |=> oc_out_n[2])
    else $error("unrouted open collector 2 conducting");
  chk_oc3_dev: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.oc_func[3] == PDA_FN_DEVIATION)
    |=> (oc_out_n[3] == !$past(loop_deviation_flag)))
    else $error("open collector 3 not following deviation");
  chk_oc3_alarm: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.oc_func[3] == PDA_FN_ALARM)
    |=> (oc_out_n[3] == !$past(fault_alarm_flag)))
    else $error("open collector 3 not following alarm");
  chk_oc3_none: assert property (@(posedge clock) disable iff (!rst_n)
    ((route_q.oc_func[3] != PDA_FN_DEVIATION) && (route_q.oc_func[3] != PDA_FN_ALARM))
    |=> oc_out_n[3])
    else $error("unrouted open collector 3 conducting");
  chk_oc4_dev: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.oc_func[4] == PDA_FN_DEVIATION)
    |=> (oc_out_n[4] == !$past(loop_deviation_flag)))
    else $error("open collector 4 not following deviation");
  chk_oc4_alarm: assert property (@(posedge clock) disable iff (!rst_n)
    (route_q.oc_func[4] == PDA_FN_ALARM)
    |=> (oc_out_n[4] == !$past(fault_alarm_flag)))
    else $error("open collector 4 not following alarm");
  chk_oc4_none: assert property (@(posedge clock) disable iff (!rst_n)
    ((route_q.oc_func[4] != PDA_FN_DEVIATION) && (route_q.oc_func[4] != PDA_FN_ALARM))
    |=> oc_out_n[4])
    else $error("unrouted open collector 4 conducting");
endmodule
`default_nettype wire

// [tb/pda_load_model.sv]
/*
  Load across the output pins: one coil or logic input on each open collector and on the relay.
  Assumes the pins are the levels driven by the block under test.
*/
`timescale 1ns/1ps
`default_nettype none
module pda_load_model (
  input wire logic [pda_pkg::PDA_NUM_OC-1:0] oc_out_n,
  input wire logic relay_energise,
  output logic [pda_pkg::PDA_NUM_OC:0] load_on
);
  import pda_pkg::*;
  // A coil pulls in only while its transistor conducts, so a low pin means energised.
  assign load_on = {relay_energise, ~oc_out_n};
endmodule
`default_nettype wire

// [tb/pda_outputs_bench.sv]
/*
  Bench for the deviation and alarm outputs.
  Assumes a 40 MHz clock and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pda_outputs_bench;
  import pda_pkg::*;
  logic clock = 0, rst_n = 0, tripped = 0, route_load = 0;
  pda_loop_t loop_in = '0;
  logic [PDA_VAL_W-1:0] thr = 16'h0010;
  pda_route_t route_in = '0;
  logic dev, alm, relay;
  logic [PDA_NUM_OC-1:0] oc_n;
  logic [PDA_NUM_OC:0] load_on;
  logic [15:0] tg [5] = '{16'h0030, 16'h0010, 16'h0020, 16'h0018, 16'h0011};
  logic [15:0] ms [5] = '{16'h0010, 16'h0030, 16'h0010, 16'h0010, 16'h0000};
  logic [4:0] ex = 5'h13;
  int failures = 0, compares = 0;
  always #12.5 clock = ~clock;
  pda_outputs pda_outputs_inst (.clock(clock), .rst_n(rst_n), .loop_in(loop_in),
    .deviation_threshold_setting(thr), .tripped(tripped), .route_load(route_load), .route_in(route_in),
    .loop_deviation_flag(dev), .fault_alarm_flag(alm), .oc_out_n(oc_n), .relay_energise(relay));
  pda_load_model pda_load_model_inst (.oc_out_n(oc_n), .relay_energise(relay), .load_on(load_on));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic route(input logic [5:0] oc, input logic [5:0] rl);
    route_in = {{PDA_NUM_OC{oc}}, rl};
    route_load = 1;
    step(1);
    route_load = 0;
  endtask
  task automatic alarm_test;
    tripped = 1;
    step(1);
    chk(alm, 1);
    step(1);
    chk(relay, 1);
    chk(oc_n, 8'h1F);
    route(PDA_FN_ALARM, PDA_FN_NONE);
    step(1);
    chk(load_on, 8'h1F);
    tripped = 0;
    step(1);
    chk(alm, 0);
    step(1);
    chk(oc_n, 8'h1F);
  endtask
  // The equal and reversed-sign cases catch a signed or non-strict compare.
  task automatic deviation_test;
    route(PDA_FN_DEVIATION, PDA_FN_NONE);
    for (int i = 0; i < 5; i++) begin
      loop_in = '{tg[i], ms[i]};
      step(1);
      chk(dev, ex[i]);
      step(1);
      chk(oc_n, {3'h0, {PDA_NUM_OC{~ex[i]}}});
      chk(relay, 0);
    end
  endtask
  // The relay carries the deviation flag; an unknown code keeps the open collectors idle.
  task automatic relay_dev_test;
    route(6'h06, PDA_FN_DEVIATION);
    step(1);
    chk(relay, 1);
    chk(oc_n, 8'h1F);
    loop_in = '{16'h0010, 16'h0010};
    step(2);
    chk(dev, 0);
    chk(relay, 0);
  endtask
  // A reset in mid-run drops every output and puts the relay back on the alarm.
  task automatic reset_test;
    route(PDA_FN_ALARM, PDA_FN_NONE);
    tripped = 1;
    rst_n = 0;
    step(2);
    chk(alm, 0);
    chk(dev, 0);
    chk(oc_n, 8'h1F);
    chk(relay, 0);
    rst_n = 1;
    step(2);
    chk(relay, 1);
    chk(oc_n, 8'h1F);
    tripped = 0;
    step(2);
    chk(relay, 0);
  endtask
  task automatic give_verdict;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    step(12);
    chk(relay, 0);
    rst_n = 1;
    alarm_test();
    deviation_test();
    relay_dev_test();
    reset_test();
    give_verdict();
  end
  initial begin
    #10us;
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire
